// ---- ext_pin_model.sv ----
// Outside world on the channel pin: a driver that reacts with a lag.
`timescale 1ns/1ps
`default_nettype none
module ext_pin_model #(
    parameter int LAG = 1       // Cycles before a new outside level reaches the wire.
) (
    input  wire logic aclk,      // Clock.
    input  wire logic ext_level, // Level the outside driver wants.
    input  wire logic pin_out,   // Level the channel drives.
    input  wire logic pin_oe_n,  // Low while the channel drives.
    output logic      pin_wire   // Resolved wire level.
);
    // A short shift stage delays the outside driver, as a board would.
    logic [3:0] lag_q = 4'h0;
    always @(posedge aclk) lag_q <= {lag_q[2:0], ext_level};
    // The channel owns the wire while it drives.
    assign pin_wire = !pin_oe_n ? pin_out : lag_q[LAG-1];
endmodule
`default_nettype wire

// ---- pin_edge_detect.v ----
// Two-flop pin synchroniser with registered rising and falling edge pulses.
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect (
    input  wire aclk,       // Timer clock.
    input  wire aresetn,    // Synchronous reset, active low.
    input  wire pin_in,     // Asynchronous pin level.
    output reg  pin_sync,   // Synchronised pin level.
    output reg  rise,       // One-cycle pulse on a rising edge.
    output reg  fall        // One-cycle pulse on a falling edge.
);

    reg         stage1;     // First synchroniser flop, read only by pin_sync.
    reg         prev;       // Previous synchronised level for edge detection.

    // -------------------------------------------------------------------------
    // Synchroniser and edge detector
    // -------------------------------------------------------------------------
    // Edges come from the second stage on, so a metastable first stage never reaches them.
    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1   <= 1'b0;
            pin_sync <= 1'b0;
            prev     <= 1'b0;
            rise     <= 1'b0;
            fall     <= 1'b0;
        end else begin
            stage1   <= pin_in;
            pin_sync <= stage1;
            prev     <= pin_sync;
            rise     <= pin_sync & ~prev;
            fall     <= ~pin_sync & prev;
        end
    end

endmodule

`default_nettype wire

// ---- tcc_map.vh ----
// Register map, field positions, reset values and bus codes of the capture/compare channel.
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define TCC_ADDR_W        5
`define TCC_OFF_CTRL      5'h00
`define TCC_OFF_VAL_HIGH  5'h04
`define TCC_OFF_VAL_LOW   5'h08
`define TCC_OFF_STATUS    5'h0C
`define TCC_OFF_MASK      5'h10
`define TCC_OFF_PARTNER   5'h14
`define TCC_OFF_PIN       5'h18

// -----------------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------------
`define TCC_CTRL_W        6
`define TCC_BIT_ELS_LO    0
`define TCC_BIT_ELS_HI    1
`define TCC_BIT_MS_UNBUF  2
`define TCC_BIT_MS_BUF    3
`define TCC_BIT_TOV       4
`define TCC_BIT_MAX       5
`define TCC_CTRL_RESET    6'h00

// -----------------------------------------------------------------------------
// Edge/level select encodings
// -----------------------------------------------------------------------------
`define TCC_ELS_NONE      2'h0
`define TCC_ELS_RISE      2'h1
`define TCC_ELS_FALL      2'h2
`define TCC_ELS_BOTH      2'h3

// -----------------------------------------------------------------------------
// Status and mask fields
// -----------------------------------------------------------------------------
`define TCC_EVT_W         2
`define TCC_BIT_CHAN_EVT  0
`define TCC_BIT_WRAP_EVT  1
`define TCC_EVT_RESET     2'h0

// -----------------------------------------------------------------------------
// Pin state fields and partner register
// -----------------------------------------------------------------------------
`define TCC_BIT_PIN_LEVEL 0
`define TCC_BIT_PIN_OWNED 1
`define TCC_BIT_CAP_BLOCK 2
`define TCC_BIT_CMP_BLOCK 3
`define TCC_PARTNER_W     8
`define TCC_PARTNER_RESET 8'h00

// -----------------------------------------------------------------------------
// AXI4-Lite response codes
// -----------------------------------------------------------------------------
`define TCC_RESP_OKAY     2'h0
`define TCC_RESP_SLVERR   2'h2

`endif

// ---- timer_channel_capture_compare.v ----
// Timer channel: input capture, output compare/PWM, preset and AXI4-Lite registers.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.vh"

module timer_channel_capture_compare (
    input  wire        aclk,                 // Timer clock, 50 MHz.
    input  wire        aresetn,              // Synchronous reset, active low.
    input  wire [15:0] counter_value,        // Shared free-running counter.
    input  wire        counter_wrap,         // One-cycle counter overflow pulse.
    input  wire        channel_pin_in,       // Pin level as seen at the pad.
    output reg         channel_pin_out,      // Level driven onto the pin.
    output reg         channel_pin_oe_n,     // Low while the channel drives the pin.
    output reg  [7:0]  partner_channel_ctrl, // Partner control as seen by the timer.
    output reg         partner_pin_release,  // High when partner pin returns to port.
    output reg         irq,                  // Level interrupt, unmasked status set.
    input  wire [4:0]  s_axi_awaddr,         // Write address.
    input  wire        s_axi_awvalid,        // Write address valid.
    output reg         s_axi_awready,        // Write address ready.
    input  wire [31:0] s_axi_wdata,          // Write data.
    input  wire [3:0]  s_axi_wstrb,          // Write byte strobes.
    input  wire        s_axi_wvalid,         // Write data valid.
    output reg         s_axi_wready,         // Write data ready.
    output reg  [1:0]  s_axi_bresp,          // Write response.
    output reg         s_axi_bvalid,         // Write response valid.
    input  wire        s_axi_bready,         // Write response ready.
    input  wire [4:0]  s_axi_araddr,         // Read address.
    input  wire        s_axi_arvalid,        // Read address valid.
    output reg         s_axi_arready,        // Read address ready.
    output reg  [31:0] s_axi_rdata,          // Read data.
    output reg  [1:0]  s_axi_rresp,          // Read response.
    output reg         s_axi_rvalid,         // Read data valid.
    input  wire        s_axi_rready          // Read data ready.
);

    // -------------------------------------------------------------------------
    // Functions
    // -------------------------------------------------------------------------
    // True when an offset names one of the mapped registers.
    function is_mapped;
        input [4:0] addr;
        begin
            is_mapped = (addr == `TCC_OFF_CTRL) || (addr == `TCC_OFF_VAL_HIGH) ||
                        (addr == `TCC_OFF_VAL_LOW) || (addr == `TCC_OFF_STATUS) ||
                        (addr == `TCC_OFF_MASK) || (addr == `TCC_OFF_PARTNER) ||
                        (addr == `TCC_OFF_PIN);
        end
    endfunction

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    reg  [5:0]  ctrl;          // Channel control bits.
    reg  [15:0] chan_value;    // Channel value register, not reset.
    reg  [15:0] active_cmp;    // Compare value in use this period.
    reg  [1:0]  status;        // Sticky event bits.
    reg  [1:0]  mask;          // Interrupt enables.
    reg  [7:0]  partner_reg;   // Stored partner control byte.
    reg         cap_block;     // Captures held off after a high-byte read.
    reg         cmp_block;     // Compares held off after a high-byte write.
    reg         full_duty;     // Full-duty request latched at a period start.
    reg         aw_got;        // Write address held.
    reg         w_got;         // Write data held.
    reg  [4:0]  aw_addr;       // Held write address.
    reg  [7:0]  w_byte;        // Held write data, low lane.
    reg         w_lane;        // Held low-lane strobe.

    // -------------------------------------------------------------------------
    // Decoded control
    // -------------------------------------------------------------------------
    wire [1:0]  els       = {ctrl[`TCC_BIT_ELS_HI], ctrl[`TCC_BIT_ELS_LO]};
    wire        ms_unbuf  = ctrl[`TCC_BIT_MS_UNBUF];
    wire        ms_buf    = ctrl[`TCC_BIT_MS_BUF];
    wire        tov       = ctrl[`TCC_BIT_TOV];
    wire        cmp_mode  = ms_unbuf | ms_buf;
    wire        cap_mode  = ~cmp_mode & (els != `TCC_ELS_NONE);
    wire        pin_owned = (els != `TCC_ELS_NONE);
    wire        pin_rise;
    wire        pin_fall;

    // Synchronised pin edges.
    pin_edge_detect u_pin_edge (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_in   (channel_pin_in),
        .pin_sync (),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    // Selected capture edge.
    wire        cap_edge  = cap_mode &
                            (((els == `TCC_ELS_RISE) & pin_rise) |
                             ((els == `TCC_ELS_FALL) & pin_fall) |
                             ((els == `TCC_ELS_BOTH) & (pin_rise | pin_fall)));
    wire        do_capture = cap_edge & ~cap_block;
    wire        cmp_match  = cmp_mode & ~cmp_block &
                             (counter_value == active_cmp);
    wire        wrap_act   = cmp_mode & tov & counter_wrap;

    reg         next_aw_got;   // Write address held next cycle.
    reg         next_w_got;    // Write data held next cycle.
    reg         next_bvalid;   // Write response pending next cycle.
    reg         next_rvalid;   // Read data pending next cycle.
    reg         do_write;      // Commit the held write this cycle.
    reg         do_read;       // Take a read address this cycle.

    // A write commits once both halves are held; channels stall while a response waits.
    always @* begin
        do_write    = aw_got & w_got & ~s_axi_bvalid;
        do_read     = s_axi_arvalid & s_axi_arready;
        next_aw_got = (aw_got | (s_axi_awvalid & s_axi_awready)) & ~do_write;
        next_w_got  = (w_got | (s_axi_wvalid & s_axi_wready)) & ~do_write;
        next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
        next_rvalid = do_read | (s_axi_rvalid & ~s_axi_rready);
    end

    // Write strobes for each writable register; read strobes only for the two value bytes, with side effects.
    wire        wr_ctrl  = do_write & w_lane & (aw_addr == `TCC_OFF_CTRL);
    wire        wr_high  = do_write & w_lane & (aw_addr == `TCC_OFF_VAL_HIGH);
    wire        wr_low   = do_write & w_lane & (aw_addr == `TCC_OFF_VAL_LOW);
    wire        wr_stat  = do_write & w_lane & (aw_addr == `TCC_OFF_STATUS);
    wire        wr_mask  = do_write & w_lane & (aw_addr == `TCC_OFF_MASK);
    wire        wr_part  = do_write & w_lane & (aw_addr == `TCC_OFF_PARTNER);
    wire        rd_high  = do_read & (s_axi_araddr == `TCC_OFF_VAL_HIGH);
    wire        rd_low   = do_read & (s_axi_araddr == `TCC_OFF_VAL_LOW);

    // -------------------------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------------------------
    // Registered readies cost an idle cycle between transfers but keep outputs on flops.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 5'h00;
            w_byte        <= 8'h00;
            w_lane        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TCC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `TCC_RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            s_axi_awready <= ~next_aw_got & ~next_bvalid & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~next_w_got & ~next_bvalid & ~(s_axi_wvalid & s_axi_wready);
            s_axi_bvalid  <= next_bvalid;
            s_axi_rvalid  <= next_rvalid;
            s_axi_arready <= ~next_rvalid & ~do_read;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (do_write) begin
                // Unmapped offsets are refused with SLVERR and change nothing.
                s_axi_bresp <= is_mapped(aw_addr) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
            end
            if (do_read) begin
                s_axi_rresp <= is_mapped(s_axi_araddr) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
                case (s_axi_araddr)
                    `TCC_OFF_CTRL: begin
                        s_axi_rdata <= {26'h0000000, ctrl};
                    end
                    `TCC_OFF_VAL_HIGH: begin
                        s_axi_rdata <= {24'h000000, chan_value[15:8]};
                    end
                    `TCC_OFF_VAL_LOW: begin
                        s_axi_rdata <= {24'h000000, chan_value[7:0]};
                    end
                    `TCC_OFF_STATUS: begin
                        s_axi_rdata <= {30'h00000000, status};
                    end
                    `TCC_OFF_MASK: begin
                        s_axi_rdata <= {30'h00000000, mask};
                    end
                    `TCC_OFF_PARTNER: begin
                        s_axi_rdata <= {24'h000000, partner_reg};
                    end
                    `TCC_OFF_PIN: begin
                        s_axi_rdata <= {28'h0000000, cmp_block, cap_block,
                                        ~channel_pin_oe_n, channel_pin_out};
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------------------
    // Control, mask, partner and interrupt status
    // -------------------------------------------------------------------------
    // A hardware event in the same cycle as a write-one clear keeps its bit.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl        <= `TCC_CTRL_RESET;
            mask        <= `TCC_EVT_RESET;
            status      <= `TCC_EVT_RESET;
            partner_reg <= `TCC_PARTNER_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= w_byte[5:0];
            end
            if (wr_mask) begin
                mask <= w_byte[1:0];
            end
            if (wr_part) begin
                partner_reg <= w_byte;
            end
            // Capture or match sets the flag; software clears it.
            status[`TCC_BIT_CHAN_EVT] <= (status[`TCC_BIT_CHAN_EVT] &
                                          ~(wr_stat & w_byte[`TCC_BIT_CHAN_EVT])) |
                                         do_capture | cmp_match;
            status[`TCC_BIT_WRAP_EVT] <= (status[`TCC_BIT_WRAP_EVT] &
                                          ~(wr_stat & w_byte[`TCC_BIT_WRAP_EVT])) |
                                         counter_wrap;
        end
    end

    // -------------------------------------------------------------------------
    // Channel value, coherency locks and compare buffer
    // -------------------------------------------------------------------------
    // No reset here: the value is undefined until a capture or a write fills it.
    always @(posedge aclk) begin
        if (do_capture) begin
            chan_value <= counter_value;
        end else if (wr_high) begin
            chan_value[15:8] <= w_byte;
        end else if (wr_low) begin
            chan_value[7:0] <= w_byte;
        end
        // Buffered compares reload at a wrap so a mid-period write cannot glitch the pulse.
        if (!ms_buf || counter_wrap) begin
            active_cmp <= chan_value;
        end
    end

    // High-byte access arms a lock that the matching low-byte access drops.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cap_block <= 1'b0;
            cmp_block <= 1'b0;
        end else begin
            if (!cap_mode || rd_low) begin
                cap_block <= 1'b0;
            end else if (rd_high) begin
                cap_block <= 1'b1;
            end
            if (!cmp_mode || wr_low) begin
                cmp_block <= 1'b0;
            end else if (wr_high) begin
                cmp_block <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Pin output logic
    // -------------------------------------------------------------------------
    // Full duty is sampled only at a wrap, so a change lands on the next period.
    always @(posedge aclk) begin
        if (!aresetn) begin
            full_duty        <= 1'b0;
            channel_pin_out  <= 1'b1;
            channel_pin_oe_n <= 1'b1;
        end else begin
            if (counter_wrap) begin
                full_duty <= ctrl[`TCC_BIT_MAX] & tov;
            end
            channel_pin_oe_n <= ~(pin_owned & cmp_mode);
            if (!pin_owned) begin
                channel_pin_out <= ~ms_unbuf;
            end else if (wrap_act) begin
                // Overflow wins over a compare in the same cycle.
                if (full_duty || (ctrl[`TCC_BIT_MAX] && tov)) begin
                    channel_pin_out <= 1'b1;
                end else begin
                    channel_pin_out <= ~channel_pin_out;
                end
            end else if (cmp_match && !(full_duty && tov)) begin
                case (els)
                    `TCC_ELS_RISE: begin
                        channel_pin_out <= ~channel_pin_out;
                    end
                    `TCC_ELS_FALL: begin
                        channel_pin_out <= 1'b0;
                    end
                    `TCC_ELS_BOTH: begin
                        channel_pin_out <= 1'b1;
                    end
                    default: begin
                        channel_pin_out <= channel_pin_out;
                    end
                endcase
            end
        end
    end

    // Partner view and interrupt output, each one cycle behind its source.
    always @(posedge aclk) begin
        if (!aresetn) begin
            partner_channel_ctrl <= `TCC_PARTNER_RESET;
            partner_pin_release  <= 1'b0;
            irq                  <= 1'b0;
        end else begin
            partner_channel_ctrl <= ms_buf ? `TCC_PARTNER_RESET : partner_reg;
            partner_pin_release  <= ms_buf;
            irq                  <= |(status & mask);
        end
    end

endmodule

`default_nettype wire

// ---- timer_channel_capture_compare_properties.sv ----
// Port-level checks for the timer capture/compare channel.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.vh"
module tcc_channel_checker (
    input wire logic        aclk,                 // Clock.
    input wire logic        aresetn,              // Reset, active low.
    input wire logic        partner_pin_release,  // Partner pin freed.
    input wire logic [7:0]  partner_channel_ctrl, // Partner control view.
    input wire logic        s_axi_awvalid,        // Write address valid.
    input wire logic        s_axi_awready,        // Write address ready.
    input wire logic        s_axi_wready,         // Write data ready.
    input wire logic        s_axi_bvalid,         // Write response valid.
    input wire logic        s_axi_bready,         // Write response ready.
    input wire logic        s_axi_arvalid,        // Read address valid.
    input wire logic        s_axi_arready,        // Read address ready.
    input wire logic [31:0] s_axi_rdata,          // Read data.
    input wire logic [1:0]  s_axi_rresp,          // Read response.
    input wire logic        s_axi_rvalid,         // Read data valid.
    input wire logic        s_axi_rready          // Read data ready.
);
    // -------------------------------------------------------------------------
    // One domain, so one clock and one reset for every property.
    // -------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data did not follow the address");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before bready");
    a_write_after_take: assert property ($rose(s_axi_bvalid) |->
        !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write response before both halves were taken");
    a_aw_ready_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready stayed high after a take");
    a_ar_ready_drop: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready returned too early");
    a_error_data_zero: assert property (s_axi_rvalid && s_axi_rresp == `TCC_RESP_SLVERR |->
        s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    a_partner_hidden: assert property (partner_pin_release |-> partner_channel_ctrl == 8'h00)
        else $error("partner control visible in buffered mode");
endmodule
bind timer_channel_capture_compare tcc_channel_checker u_tcc_channel_checker (.*);
`default_nettype wire

// ---- timer_channel_capture_compare_tb_top.sv ----
// Register-level testbench of the timer capture/compare channel.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_map.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t: got %h want %h", $time, (g), (e)); end end
module timer_channel_capture_compare_tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0, counter_wrap = 1'b0, ext_level = 1'b0;
    logic [15:0] counter_value = 16'h1234;
    logic        channel_pin_in, channel_pin_out, channel_pin_oe_n, partner_pin_release, irq;
    logic [7:0]  partner_channel_ctrl;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
    int          err_count = 0, n_tests = 0;
    timer_channel_capture_compare u_timer_channel_capture_compare (.*);
    ext_pin_model u_ext_pin_model (.aclk(aclk), .ext_level(ext_level), .pin_out(channel_pin_out),
        .pin_oe_n(channel_pin_oe_n), .pin_wire(channel_pin_in));
    initial forever #10 aclk = ~aclk;
    // One bus access; ready and answer are read at the falling edge.
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d);
        logic ta, tw, tr, dn;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= {24'h000000, d};
            s_axi_awvalid <= wr;
            s_axi_wvalid <= wr;
            s_axi_arvalid <= !wr;
            s_axi_bready <= wr;
            s_axi_rready <= !wr;
            do begin
                @(negedge aclk);
                ta = s_axi_awready;
                tw = s_axi_wready;
                tr = s_axi_arready;
                dn = s_axi_bvalid || s_axi_rvalid;
                rd_d = s_axi_rdata;
                rd_r = wr ? s_axi_bresp : s_axi_rresp;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                if (tr) s_axi_arvalid <= 1'b0;
            end while (!dn);
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
        end
    endtask
    // One counter value and wrap flag for a single cycle.
    task automatic step(input logic [15:0] v, input logic w);
        begin
            counter_value <= v;
            counter_wrap <= w;
            @(posedge aclk);
            counter_value <= 16'h0000;
            counter_wrap <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask
    task automatic give_verdict;
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // Hang guard, far past the test length.
    initial begin
        #400us;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        xfer(1'b0, 5'h1C, 8'h00);
        `CHK(rd_r, `TCC_RESP_SLVERR);
        xfer(1'b0, `TCC_OFF_CTRL, 8'h00);
        `CHK(rd_d, 32'h0);
        xfer(1'b1, 5'h1C, 8'h00);
        `CHK(rd_r, `TCC_RESP_SLVERR);
        $display("reset and map test done");
        // Counter held still over mode changes.
        for (int m = 1; m < 4; m++) begin
            xfer(1'b1, `TCC_OFF_CTRL, 8'(m));
            xfer(1'b1, `TCC_OFF_STATUS, 8'h03);
            for (int e = 0; e < 2; e++) begin
                ext_level <= (e == 0);
                repeat (10) @(posedge aclk);
                xfer(1'b0, `TCC_OFF_STATUS, 8'h00);
                `CHK(rd_d[0], m[e]);
                xfer(1'b1, `TCC_OFF_STATUS, 8'h01);
            end
        end
        xfer(1'b1, `TCC_OFF_MASK, 8'h01);
        ext_level <= 1'b1;
        repeat (10) @(posedge aclk);
        `CHK(irq, 1'b1);
        xfer(1'b0, `TCC_OFF_VAL_HIGH, 8'h00);
        `CHK(rd_d, 32'h12);
        counter_value <= 16'h5678;
        ext_level <= 1'b0;
        repeat (10) @(posedge aclk);
        xfer(1'b0, `TCC_OFF_VAL_LOW, 8'h00);
        `CHK(rd_d, 32'h34);
        xfer(1'b1, `TCC_OFF_STATUS, 8'h03);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0);
        $display("capture test done");
        counter_value <= 16'h0000;
        xfer(1'b1, `TCC_OFF_CTRL, 8'h06);
        xfer(1'b1, `TCC_OFF_VAL_HIGH, 8'h00);
        xfer(1'b1, `TCC_OFF_VAL_LOW, 8'h10);
        // Clear, set, toggle, toggle.
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, `TCC_OFF_CTRL, 8'h04 | ((8'h5E >> (2 * i)) & 8'h03));
            step(16'h0010, 1'b0);
            `CHK({channel_pin_oe_n, channel_pin_out}, {1'b0, i[0]});
        end
        xfer(1'b1, `TCC_OFF_VAL_HIGH, 8'h00);
        step(16'h0010, 1'b0);
        `CHK(channel_pin_out, 1'b1);
        xfer(1'b1, `TCC_OFF_VAL_LOW, 8'h10);
        step(16'h0010, 1'b0);
        `CHK(channel_pin_out, 1'b0);
        xfer(1'b1, `TCC_OFF_CTRL, 8'h16);
        step(16'h0010, 1'b1);
        `CHK(channel_pin_out, 1'b1);
        step(16'h0000, 1'b1);
        `CHK(channel_pin_out, 1'b0);
        xfer(1'b1, `TCC_OFF_CTRL, 8'h35);
        step(16'h0000, 1'b1);
        `CHK(channel_pin_out, 1'b1);
        step(16'h0010, 1'b0);
        `CHK(channel_pin_out, 1'b1);
        xfer(1'b0, `TCC_OFF_VAL_LOW, 8'h00);
        `CHK(rd_d, 32'h10);
        $display("compare test done");
        xfer(1'b1, `TCC_OFF_CTRL, 8'h04);
        repeat (2) @(posedge aclk);
        `CHK({channel_pin_oe_n, channel_pin_out}, 2'b10);
        xfer(1'b1, `TCC_OFF_PARTNER, 8'hA5);
        `CHK(rd_r, `TCC_RESP_OKAY);
        xfer(1'b1, `TCC_OFF_CTRL, 8'h0D);
        repeat (2) @(posedge aclk);
        `CHK({partner_pin_release, partner_channel_ctrl}, 9'h100);
        $display("preset and pairing test done");
        give_verdict();
    end
endmodule
`default_nettype wire
